// ### rtl/ops_pkg.sv
// Shared constants and carrier types for the octal port status block.
// Assumes an 8-bit host bus whose address splits into port and offset.
package ops_pkg;

  localparam int NPORT = 8;
  localparam int TX_CNT_W = 16;

  // Address split: upper three bits pick the port alias, lower five the
  // register within the 32-byte port window.
  localparam int ADDR_W = 8;
  localparam int PORT_MSB = 7;
  localparam int PORT_LSB = 5;
  localparam int OFS_MSB = 4;
  localparam logic [2:0] PORT_FIRST = 3'h0;

  localparam logic [4:0] OFS_CNT_LATCH = 5'h01;
  localparam logic [4:0] OFS_CNT_HIGH = 5'h02;
  localparam logic [4:0] OFS_CNT_LOW = 5'h03;
  localparam logic [4:0] OFS_FILLER = 5'h04;
  localparam logic [4:0] OFS_HEC_PAT = 5'h05;
  localparam logic [4:0] OFS_TX_CTRL = 5'h06;
  localparam logic [4:0] OFS_ISR = 5'h08;
  localparam logic [4:0] OFS_RX_CFG = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam logic [4:0] OFS_RX_CTRL = 5'h1A;

  // Reset values.
  localparam logic [7:0] FILLER_RESET = 8'h6A;
  localparam logic [7:0] HEC_PAT_RESET = 8'h29;
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [7:0] RX_CFG_FIXED = 8'h10;
  localparam logic [7:0] TX_CTRL_RESET = 8'h01;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Hec corruption pattern fields.
  localparam int BAD_MSB = 2;
  localparam int GOOD_MSB = 7;
  localparam int GOOD_LSB = 3;

  // Port status bit positions.
  localparam int ST_OVERRUN = 0;
  localparam int ST_LCD_CHG = 1;
  localparam int ST_LCD = 2;
  localparam int ST_RMODE = 3;
  localparam int ST_DS_LO = 4;
  localparam int ST_DS_HI = 5;
  localparam int ST_PARITY = 6;
  localparam int ST_EXT = 7;
  localparam logic [7:0] EV_MASK = 8'hC3;

  // Transmit control bit positions.
  localparam int TX_HEC_INS = 0;
  localparam int TX_HEC_CORRUPT = 1;
  localparam int TX_PAR_MASK = 6;

  // Receive control bit positions (interrupt masks).
  localparam int RX_OVR_MASK = 3;
  localparam int RX_LCD_MASK = 4;
  localparam int RX_EXT_MASK = 5;

  // Receive configuration bit positions.
  localparam int RC_FORMAT = 0;
  localparam int RC_POLL = 1;
  localparam int RC_ADDR_LO = 2;
  localparam int RC_ADDR_HI = 3;
  localparam logic [1:0] RC_TOP_RANGE = 2'h3;
  localparam int NULL_PORT = 7;

  typedef enum logic {HEC_GOOD = 1'b0, HEC_BAD = 1'b1} ops_hec_phase_e;

  // Live and event inputs from one port's receive and transmit paths.
  typedef struct packed {
    logic rx_overrun;
    logic loss_of_cell_delineation;
    logic receiver_mode;
    logic [1:0] delineation_state;
    logic tx_parity_error;
    logic external_status_input;
  } ops_stat_in_s;

endpackage

// ### rtl/ops_port_slice.sv
// One port's status register, transmitted-cell counter and hec
// corruption sequencer. Inputs are synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module ops_port_slice
  import ops_pkg::*;
#(
  parameter int CNT_W = TX_CNT_W
)(
  input wire logic core_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire ops_stat_in_s stat_in, // Live conditions and event pulses.
  input wire logic cell_sent, // One assigned cell sent this cycle.
  input wire logic hec_cell, // A cell's hec byte was sent.
  input wire logic corrupt_en, // Hec corruption enable.
  input wire logic [7:0] irq_mask, // Masks aligned to status bits.
  input wire logic status_rd, // Host reads this status register.
  input wire logic count_latch, // Host latches this counter.
  input wire logic [2:0] bad_len, // Cells with a bad hec.
  input wire logic [4:0] good_len, // Cells with a good hec.
  output logic [7:0] status_q, // Status register.
  output logic irq_q, // Port raises an interrupt.
  output logic [CNT_W-1:0] count_q, // Running cell count.
  output logic hec_bad_q // Corrupt the next cell's hec.
);

  logic [7:0] status_d;
  logic [7:0] ev_new;
  logic [7:0] ev_old;
  logic irq_d;
  logic ext_prev_q, ext_prev_d;
  logic [CNT_W-1:0] count_d;
  ops_hec_phase_e phase_q, phase_d;
  logic [4:0] run_q, run_d;
  logic hec_bad_d;

  // Events captured in the value being read are cleared; an event that
  // lands in the read cycle is kept for the next read.
  always_comb
  begin
    ev_new = 8'h00;
    ev_new[ST_OVERRUN] = stat_in.rx_overrun;
    ev_new[ST_LCD_CHG] = stat_in.loss_of_cell_delineation
                         != status_q[ST_LCD];
    ev_new[ST_PARITY] = stat_in.tx_parity_error;
    ev_new[ST_EXT] = stat_in.external_status_input
                     && !ext_prev_q;
    ev_old = status_rd ? 8'h00 : (status_q & EV_MASK);
    status_d = ev_old | ev_new;
    status_d[ST_LCD] = stat_in.loss_of_cell_delineation;
    status_d[ST_RMODE] = stat_in.receiver_mode;
    status_d[ST_DS_HI:ST_DS_LO] = stat_in.delineation_state;
    irq_d = |(status_d & irq_mask & EV_MASK);
    ext_prev_d = stat_in.external_status_input;
  end

  // A latch restarts the count; a cell in the latch cycle is not lost.
  always_comb
  begin
    if (count_latch)
      count_d = {{(CNT_W-1){1'b0}}, cell_sent};
    else
      count_d = count_q + {{(CNT_W-1){1'b0}}, cell_sent};
  end

  // Good run of good_len cells, then bad run of bad_len, repeating.
  // The pattern ignores whether the hec itself is computed.
  always_comb
  begin
    phase_d = phase_q;
    run_d = run_q;
    if (!corrupt_en)
    begin
      phase_d = HEC_GOOD;
      run_d = 5'h00;
    end
    else if (hec_cell)
    begin
      run_d = run_q + 5'h01;
      unique case (phase_q)
        HEC_GOOD:
        begin
          if (run_d >= good_len)
          begin
            run_d = 5'h00;
            if (bad_len != 3'h0)
              phase_d = HEC_BAD;
          end
        end
        HEC_BAD:
        begin
          if (run_d >= {2'h0, bad_len})
          begin
            run_d = 5'h00;
            phase_d = HEC_GOOD;
          end
        end
      endcase
    end
    hec_bad_d = corrupt_en && (phase_d == HEC_BAD);
  end

  // State registers.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      status_q <= STATUS_RESET;
      irq_q <= 1'b0;
      ext_prev_q <= 1'b0;
      count_q <= '0;
      phase_q <= HEC_GOOD;
      run_q <= 5'h00;
      hec_bad_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q <= irq_d;
      ext_prev_q <= ext_prev_d;
      count_q <= count_d;
      phase_q <= phase_d;
      run_q <= run_d;
      hec_bad_q <= hec_bad_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  overrun_sets_a: assert property (stat_in.rx_overrun |=>
    status_q[ST_OVERRUN]) else $error("overrun event lost");
  lcd_live_a: assert property (##1 status_q[ST_LCD] ==
    $past(stat_in.loss_of_cell_delineation)) else $error("lcd not live");
  ext_edge_a: assert property (!stat_in.external_status_input ##1
    stat_in.external_status_input |=> status_q[ST_EXT])
    else $error("external rising edge missed");
  read_clears_a: assert property (status_rd && ev_new == 8'h00 |=>
    (status_q & EV_MASK) == 8'h00 && !irq_q) else $error("read kept events");
  corrupt_off_a: assert property (!corrupt_en |=>
    !hec_bad_q) else $error("hec corrupted while disabled");
  cover_bad_run_c: cover property (corrupt_en && hec_bad_q ##1
    !hec_bad_q);
endmodule

`default_nettype wire

// ### rtl/ops_regs.sv
// Register bank and status logic for one eight-port block.
// Host bus: 8-bit address and data, one-cycle read and write strobes,
// synchronous to core_clk; read data appears one cycle after the strobe.
//
// What this block does
// - Sixteen-bit read-only transmitted cell count.
// - Count bytes shared, visible at every alias.
// - Count reads return last latched value.
// - Shared filler payload byte, resets to 6A.
// - Pattern bits 2:0 give bad-hec run.
// - Pattern bits 7:3 give good-hec run.
// - Alternate good then bad runs while enabled.
// - Pattern applies regardless of hec insertion.
// - Overrun event bit, clear on read, maskable.
// - Delineation change event, clear on read, maskable.
// - Live delineation lost flag, resets to one.
// - Receiver mode flag: correction or detection.
// - Bits 5:4 give hunt, presync, sync.
// - Parity error event, clear on read, maskable.
// - External input rising edge event, maskable.
// - Summary bit per port from masked events.
// - Status read clears port summary bit.
// - Config bit 0 selects receive line format.
// - Config bit 1 selects receive polling style.
// - Config bits 3:2 set upper port address.
// - Latch write copies count, then clears it.
// - Per-port enable gates hec corruption.
`timescale 1ns/10ps
`default_nettype none

module ops_regs
  import ops_pkg::*;
#(
  parameter int NP = NPORT,
  parameter int CNT_W = TX_CNT_W
)(
  input wire logic core_clk, // System clock, 200 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] bus_addr, // Register address.
  input wire logic [7:0] bus_wdata, // Write data.
  input wire logic bus_wr, // Write strobe, one cycle.
  input wire logic bus_rd, // Read strobe, one cycle.
  output logic [7:0] bus_rdata_q, // Read data, one cycle later.
  input wire ops_stat_in_s [NP-1:0] port_stat, // Per-port conditions.
  input wire logic [NP-1:0] cell_sent, // Assigned cell sent, per port.
  input wire logic [NP-1:0] hec_cell, // Hec byte sent, per port.
  output logic [NP-1:0] hec_corrupt, // Corrupt next hec, per port.
  output logic [NP-1:0] hec_insert_enable, // Compute hec, per port.
  output logic [7:0] filler_payload_octet, // Idle cell payload octet.
  output logic rx_line_format, // Receive format: 0 T1, 1 E1.
  output logic rx_poll_select, // 0 multiplexed, 1 direct status.
  output logic [1:0] rx_upper_address, // Upper port address bits.
  output logic [NP-1:0] rx_port_active_q, // Port answers polling.
  output logic int_n_q // Interrupt, active low.
);

  logic [2:0] sel_port;
  logic [4:0] sel_ofs;
  logic at_first;
  logic [NP-1:0] port_hit;
  logic wr_latch;
  logic [NP-1:0] latch_vec;
  logic [NP-1:0] status_rd_vec;

  logic [CNT_W-1:0] cnt_latch_q, cnt_latch_d;
  logic [7:0] filler_q, filler_d;
  logic [7:0] hec_pat_q, hec_pat_d;
  logic [3:0] rx_cfg_q, rx_cfg_d;
  logic [NP-1:0][7:0] tx_ctrl_q, tx_ctrl_d;
  logic [NP-1:0][7:0] rx_ctrl_q, rx_ctrl_d;
  logic [7:0] rdata_d;
  logic int_n_d;
  logic [NP-1:0] active_d;

  logic [NP-1:0][7:0] slice_status;
  logic [NP-1:0][CNT_W-1:0] slice_count;
  logic [NP-1:0] slice_irq;
  logic [NP-1:0][7:0] slice_mask;

  // Address decode: per-port registers repeat every 32 bytes, while the
  // block-wide registers other than the shared count bytes answer only in the first port window.
  always_comb
  begin
    sel_port = bus_addr[PORT_MSB:PORT_LSB];
    sel_ofs = bus_addr[OFS_MSB:0];
    at_first = (sel_port == PORT_FIRST);
    port_hit = NP'(1) << sel_port;
    wr_latch = bus_wr && (sel_ofs == OFS_CNT_LATCH);
    latch_vec = wr_latch ? port_hit : '0;
    status_rd_vec = (bus_rd && sel_ofs == OFS_STATUS) ? port_hit : '0;
  end

  // Shared count latch: loaded only by a latch write, so reads between
  // latches keep returning the captured value.
  always_comb
  begin
    if (wr_latch)
      cnt_latch_d = slice_count[sel_port];
    else
      cnt_latch_d = cnt_latch_q;
  end

  // Shared and per-port control registers written by the host.
  always_comb
  begin
    filler_d = filler_q;
    hec_pat_d = hec_pat_q;
    rx_cfg_d = rx_cfg_q;
    tx_ctrl_d = tx_ctrl_q;
    rx_ctrl_d = rx_ctrl_q;
    if (bus_wr)
    begin
      if (at_first && sel_ofs == OFS_FILLER)
        filler_d = bus_wdata;
      if (at_first && sel_ofs == OFS_HEC_PAT)
        hec_pat_d = bus_wdata;
      if (at_first && sel_ofs == OFS_RX_CFG)
        rx_cfg_d = bus_wdata[RC_ADDR_HI:0];
      if (sel_ofs == OFS_TX_CTRL)
        tx_ctrl_d[sel_port] = bus_wdata;
      if (sel_ofs == OFS_RX_CTRL)
        rx_ctrl_d[sel_port] = bus_wdata;
    end
  end

  // Read mux. Unmapped offsets, and the write-only latch, read as zero.
  // Count bytes answer at every alias so software need not track which
  // port it latched.
  always_comb
  begin
    rdata_d = READ_NONE;
    if (bus_rd)
    begin
      unique case (sel_ofs)
        OFS_CNT_HIGH: rdata_d = cnt_latch_q[CNT_W-1:8];
        OFS_CNT_LOW: rdata_d = cnt_latch_q[7:0];
        OFS_FILLER: rdata_d = at_first ? filler_q : READ_NONE;
        OFS_HEC_PAT: rdata_d = at_first ? hec_pat_q : READ_NONE;
        OFS_ISR: rdata_d = at_first ? slice_irq : READ_NONE;
        OFS_RX_CFG:
          rdata_d = at_first ? (RX_CFG_FIXED | {4'h0, rx_cfg_q})
                             : READ_NONE;
        OFS_STATUS: rdata_d = slice_status[sel_port];
        OFS_TX_CTRL: rdata_d = tx_ctrl_q[sel_port];
        OFS_RX_CTRL: rdata_d = rx_ctrl_q[sel_port];
        default: rdata_d = READ_NONE;
      endcase
    end
  end

  // Interrupt output and receive polling map. The top address range
  // leaves the last port at the null address 31, which never answers.
  always_comb
  begin
    int_n_d = !(|slice_irq);
    active_d = '1;
    if (rx_cfg_q[RC_ADDR_HI:RC_ADDR_LO] == RC_TOP_RANGE)
      active_d[NULL_PORT] = 1'b0;
  end

  // Register stage for everything above.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_latch_q <= '0;
      filler_q <= FILLER_RESET;
      hec_pat_q <= HEC_PAT_RESET;
      rx_cfg_q <= 4'h0;
      tx_ctrl_q <= {NP{TX_CTRL_RESET}};
      rx_ctrl_q <= {NP{RX_CTRL_RESET}};
      bus_rdata_q <= READ_NONE;
      int_n_q <= 1'b1;
      rx_port_active_q <= '1;
    end
    else
    begin
      cnt_latch_q <= cnt_latch_d;
      filler_q <= filler_d;
      hec_pat_q <= hec_pat_d;
      rx_cfg_q <= rx_cfg_d;
      tx_ctrl_q <= tx_ctrl_d;
      rx_ctrl_q <= rx_ctrl_d;
      bus_rdata_q <= rdata_d;
      int_n_q <= int_n_d;
      rx_port_active_q <= active_d;
    end
  end

  // Outputs taken directly from their control flops.
  assign filler_payload_octet = filler_q;
  assign rx_line_format = rx_cfg_q[RC_FORMAT];
  assign rx_poll_select = rx_cfg_q[RC_POLL];
  assign rx_upper_address = rx_cfg_q[RC_ADDR_HI:RC_ADDR_LO];

  // One slice per port; the masks are rearranged to line up with the
  // status bits so the slice can gate them with a single AND.
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    always_comb
    begin
      slice_mask[p] = 8'h00;
      slice_mask[p][ST_OVERRUN] = rx_ctrl_q[p][RX_OVR_MASK];
      slice_mask[p][ST_LCD_CHG] = rx_ctrl_q[p][RX_LCD_MASK];
      slice_mask[p][ST_PARITY] = tx_ctrl_q[p][TX_PAR_MASK];
      slice_mask[p][ST_EXT] = rx_ctrl_q[p][RX_EXT_MASK];
    end
    assign hec_insert_enable[p] = tx_ctrl_q[p][TX_HEC_INS];

    ops_port_slice #(
      .CNT_W(CNT_W)
    ) u_slice (
      .core_clk(core_clk),
      .reset(reset),
      .stat_in(port_stat[p]),
      .cell_sent(cell_sent[p]),
      .hec_cell(hec_cell[p]),
      .corrupt_en(tx_ctrl_q[p][TX_HEC_CORRUPT]),
      .irq_mask(slice_mask[p]),
      .status_rd(status_rd_vec[p]),
      .count_latch(latch_vec[p]),
      .bad_len(hec_pat_q[BAD_MSB:0]),
      .good_len(hec_pat_q[GOOD_MSB:GOOD_LSB]),
      .status_q(slice_status[p]),
      .irq_q(slice_irq[p]),
      .count_q(slice_count[p]),
      .hec_bad_q(hec_corrupt[p])
    );
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Latch write takes the selected port's running count.
  latch_capture_a: assert property (wr_latch |=>
    cnt_latch_q == $past(slice_count[sel_port]))
    else $error("latch did not capture port count");

  // Without a latch write the shared value never moves.
  latch_holds_a: assert property (!wr_latch |=>
    $stable(cnt_latch_q)) else $error("latched count changed");

  // Count high byte reads the latch at any alias.
  count_high_read_a: assert property (bus_rd && sel_ofs == OFS_CNT_HIGH
    && !wr_latch |=> bus_rdata_q == cnt_latch_q[CNT_W-1:8])
    else $error("count high byte wrong");

  // Filler byte comes out of reset at its reset value; this check must
  // stay live while reset is high, so it is never disabled.
  filler_reset_a: assert property (disable iff (1'b0) reset |=>
    filler_payload_octet == FILLER_RESET) else $error("filler reset wrong");

  // A status read drops the port's summary bit when nothing new arrives.
  summary_clear_a: assert property (status_rd_vec[sel_port] &&
    !port_stat[sel_port].rx_overrun && !port_stat[sel_port].tx_parity_error
    && !port_stat[sel_port].external_status_input
    && port_stat[sel_port].loss_of_cell_delineation
       == slice_status[sel_port][ST_LCD]
    |=> !slice_irq[$past(sel_port)])
    else $error("summary bit survived read");

  // Interrupt pin follows the summary one cycle later.
  int_follow_a: assert property (##1 int_n_q ==
    !$past(|slice_irq)) else $error("interrupt pin out of step");

  // Config write reaches the line format output next cycle.
  cfg_format_a: assert property (bus_wr && at_first &&
    sel_ofs == OFS_RX_CFG |=> rx_line_format == $past(bus_wdata[RC_FORMAT]))
    else $error("line format not written");

  // Top address range leaves the null-address port silent.
  null_port_a: assert property (rx_upper_address == RC_TOP_RANGE
    |=> !rx_port_active_q[NULL_PORT]) else $error("port 31 answered");

  cover_latch_read_c: cover property (wr_latch ##[1:4]
    bus_rd && sel_ofs == OFS_CNT_LOW);
  cover_irq_c: cover property ($fell(int_n_q));
  cover_clear_c: cover property (|status_rd_vec ##2 $rose(int_n_q));
endmodule

`default_nettype wire

// ### verification/ops_host_model.sv
// Host processor model that drives the 8-bit register bus of the bank.
// Assumes one-cycle strobes and read data valid one cycle after them.
`timescale 1ns/10ps
`default_nettype none

module ops_host_model
(
  input wire logic core_clk, // System clock.
  output logic [7:0] bus_addr, // Register address.
  output logic [7:0] bus_wdata, // Write data.
  output logic bus_wr, // Write strobe.
  output logic bus_rd, // Read strobe.
  input wire logic [7:0] bus_rdata_q // Read data from the bank.
);
  // An idle bus shows inverted values, so a stale address is never trusted.
  initial
  begin
    bus_addr = 8'hFF;
    bus_wdata = 8'hFF;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // Callers enter just after a rising edge; each strobe lasts one cycle.
  // An idle edge follows, so a next call never re-raises a strobe in the
  // same time step that lowered it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge core_clk);
    #1;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
    @(posedge core_clk);
    #1;
  endtask

  // Read data stands only in the cycle after the strobe edge, so it is
  // taken there; the next edge already returns the bus to zero.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge core_clk);
    #1;
    bus_rd = 1'b0;
    bus_addr = ~a;
    d = bus_rdata_q;
    @(posedge core_clk);
    #1;
  endtask

  // Latch port p first, then read both bytes at alias q.
  task automatic count(input logic [2:0] p, input logic [2:0] q,
                       output logic [15:0] w);
    wr({p, 5'h01}, 8'h00);
    rd({q, 5'h02}, w[15:8]);
    rd({q, 5'h03}, w[7:0]);
  endtask
endmodule
`default_nettype wire

// ### verification/octal_port_status_and_tx_cfg_bench.sv
// Self-checking bench for the octal port register bank.
// Assumes ops_pkg, ops_regs and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module octal_port_status_and_tx_cfg_bench;
  import ops_pkg::*;
  logic core_clk;
  logic reset;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata_q;
  ops_stat_in_s [7:0] stat;
  logic [7:0] cell_sent;
  logic [7:0] hec_cell;
  logic [7:0] hec_corrupt;
  logic [7:0] hec_ins;
  logic [7:0] filler;
  logic fmt;
  logic poll;
  logic [1:0] upper;
  logic [7:0] active;
  logic int_n_q;
  int n_fail;
  int n_tests;
  int cnt[8];
  logic [7:0] ev[8];
  logic [7:0] rd_v;
  logic [7:0] rxm[4] = '{8'h08, 8'h10, 8'h00, 8'h20};
  int evb[4] = '{0, 1, 6, 7};

  ops_regs dut (.core_clk(core_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q), .port_stat(stat), .cell_sent(cell_sent),
    .hec_cell(hec_cell), .hec_corrupt(hec_corrupt),
    .hec_insert_enable(hec_ins), .filler_payload_octet(filler),
    .rx_line_format(fmt), .rx_poll_select(poll),
    .rx_upper_address(upper), .rx_port_active_q(active),
    .int_n_q(int_n_q));

  ops_host_model host (.core_clk(core_clk), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q));

  // Clock at 200 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] adr(input int p, input logic [4:0] o);
    return {p[2:0], o};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Expected status is pending events merged with the live inputs.
  task automatic chk_status(input int p);
    logic [7:0] e;
    e = ev[p] | {2'b00, stat[p].delineation_state, stat[p].receiver_mode,
      stat[p].loss_of_cell_delineation, 2'b00};
    host.rd(adr(p, OFS_STATUS), rd_v);
    chk(rd_v, e, "status");
    ev[p] = 8'h00;
  endtask

  // Event pulses last one cycle; the external input stays high.
  task automatic fire(input int p, input int k);
    case (k)
      0: stat[p].rx_overrun = 1'b1;
      1: stat[p].loss_of_cell_delineation =
           ~stat[p].loss_of_cell_delineation;
      2: stat[p].tx_parity_error = 1'b1;
      default: stat[p].external_status_input = 1'b1;
    endcase
    @(posedge core_clk);
    #1;
    stat[p].rx_overrun = 1'b0;
    stat[p].tx_parity_error = 1'b0;
  endtask

  // A hang is cut short and reported as a mismatch.
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    int p;
    int q;
    int g;
    int b;
    int n;
    int seed_v;
    logic m;
    logic bad;
    logic [15:0] w;
    logic [15:0] lat;
    seed_v = $urandom(32'h6c93ce34);
    n_fail = 0;
    n_tests = 0;
    reset = 1'b1;
    stat = '0;
    cell_sent = 8'h00;
    hec_cell = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      stat[i].loss_of_cell_delineation = 1'b1;
      cnt[i] = 0;
      ev[i] = 8'h00;
    end
    repeat (6) @(posedge core_clk);
    #1;
    reset = 1'b0;

    // Reset values and refused accesses.
    chk(filler, 8'h6A, "filler out");
    chk(hec_ins, 8'hFF, "insert out");
    chk({7'h00, int_n_q}, 8'h01, "irq idle");
    host.rd(8'h05, rd_v);
    chk(rd_v, 8'h29, "pattern rst");
    host.rd(8'h10, rd_v);
    chk(rd_v, 8'h10, "config rst");
    chk_status(0);
    host.wr(8'h24, 8'h00);
    host.wr(8'h08, 8'hFF);
    host.rd(8'h04, rd_v);
    chk(rd_v, 8'h6A, "filler rst");
    host.rd(8'h08, rd_v);
    chk(rd_v, 8'h00, "summary ro");
    host.rd(8'h1F, rd_v);
    chk(rd_v, 8'h00, "unmapped");
    w[7:0] = 8'($urandom);
    host.wr(8'h04, w[7:0]);
    host.rd(8'h04, rd_v);
    chk(rd_v, w[7:0], "filler rw");
    chk(filler, w[7:0], "filler out");
    $display("test reset_and_refusals done");

    // Counts latched per port, read at random aliases.
    for (int r = 0; r < 3; r++)
    begin
      repeat (200)
      begin
        cell_sent = 8'($urandom);
        @(posedge core_clk);
        for (int i = 0; i < 8; i++)
          cnt[i] += cell_sent[i];
        #1;
      end
      cell_sent = 8'h00;
      p = $urandom_range(7);
      q = $urandom_range(7);
      host.count(p[2:0], q[2:0], w);
      lat = cnt[p][15:0];
      cnt[p] = 0;
      chk(w[15:8], lat[15:8], "count high");
      chk(w[7:0], lat[7:0], "count low");
      cell_sent = 8'hFF;
      repeat (5) @(posedge core_clk);
      #1;
      cell_sent = 8'h00;
      for (int i = 0; i < 8; i++)
        cnt[i] += 5;
      host.rd(adr(7 - q, OFS_CNT_LOW), rd_v);
      chk(rd_v, lat[7:0], "stale count");
    end
    $display("test cell_count done");

    // Good and bad hec runs with insertion itself switched off.
    g = $urandom_range(31, 1);
    b = $urandom_range(7, 1);
    host.wr(8'h05, {g[4:0], b[2:0]});
    p = $urandom_range(7);
    host.wr(adr(p, OFS_TX_CTRL), 8'h02);
    chk(hec_ins, ~(8'h01 << p), "insert off");
    bad = 1'b0;
    n = 0;
    repeat (120)
    begin
      hec_cell[p] = 1'($urandom_range(1));
      @(posedge core_clk);
      #1;
      if (hec_cell[p])
      begin
        n++;
        if (!bad && n >= g)
        begin
          bad = 1'b1;
          n = 0;
        end
        else if (bad && n >= b)
        begin
          bad = 1'b0;
          n = 0;
        end
      end
      chk(8'(hec_corrupt[p]), 8'(bad), "hec");
    end
    hec_cell = 8'h00;
    host.wr(adr(p, OFS_TX_CTRL), 8'h01);
    @(posedge core_clk);
    #1;
    chk(hec_corrupt, 8'h00, "hec off");
    $display("test hec_pattern done");

    // Every event kind, masked or not, on a random port.
    for (int k = 0; k < 4; k++)
    begin
      p = $urandom_range(7);
      m = 1'($urandom_range(1));
      stat[p].receiver_mode = 1'($urandom_range(1));
      stat[p].delineation_state = 2'($urandom_range(3));
      host.wr(adr(p, OFS_RX_CTRL), m ? rxm[k] : 8'h00);
      host.wr(adr(p, OFS_TX_CTRL), (m && k == 2) ? 8'h41 : 8'h01);
      fire(p, k);
      ev[p][evb[k]] = 1'b1;
      host.rd(8'h08, rd_v);
      chk(rd_v, m ? (8'h01 << p) : 8'h00, "summary");
      chk(8'(int_n_q), {7'h00, ~m}, "irq");
      chk_status(p);
      host.rd(8'h08, rd_v);
      chk(rd_v, 8'h00, "summary clr");
      chk({7'h00, int_n_q}, 8'h01, "irq clr");
      stat[p].external_status_input = 1'b0;
    end
    // An event landing with the read stays for the next read.
    p = 3;
    fork
      host.rd(adr(p, OFS_STATUS), rd_v);
      begin
        stat[p].rx_overrun = 1'b1;
        @(posedge core_clk);
        #1;
        stat[p].rx_overrun = 1'b0;
      end
    join
    chk(rd_v & 8'h01, 8'h00, "late event");
    ev[p][0] = 1'b1;
    chk_status(p);
    $display("test status_events done");

    // Every address range; one block only, so any range is legal here.
    for (int c = 0; c < 4; c++)
    begin
      w[3:0] = {c[1:0], 2'($urandom_range(3))};
      host.wr(8'h10, {4'h0, w[3:0]});
      host.rd(8'h10, rd_v);
      chk(rd_v, {4'h1, w[3:0]}, "config");
      chk(8'({upper, poll}), 8'(w[3:1]), "cfg out");
      chk({7'h00, fmt}, {7'h00, w[0]}, "format");
      chk(active, (c == 3) ? 8'h7F : 8'hFF, "active");
    end
    $display("test rx_config done");
    results();
  end
endmodule
`default_nettype wire
